// *** design/config_lock_and_timestamp_regs.sv ***
// Purpose: Channel-six timestamps, bank select and double group lock
// Assumes: Byte register port driven by the serial engine on clk
// Notes: Lock bits only clear by reset, soft reset or self check
// Function
// - Read-only high timestamp byte, channel six
// - Read-only low timestamp byte, channel six
// - Stamp is sequence timer count
// - Rising code 01 latches at slow undervolt
// - Falling code 10 latches at off threshold
// - Timer advances every 50 us
// - Bank bit zero steers accesses, resets zero
// - Group locked only when both registers set
// - Lock registers reset zero, never host-cleared
// - Clear by power, soft reset, self check
// - Bits five, four lock working groups
// - Bits three, two lock config, irq enable
// - Bit zero locks ordering group
// - Bit one locks selected watch channels
// - Bits seven, six reserved, no effect
// - Channel select defaults all ones
`timescale 1ns/1ps
`default_nettype none
module config_lock_and_timestamp_regs
  import lock_stamp_pkg::*;
#(
  parameter int TICK_CYCLES = lock_stamp_pkg::TICK_CYC
) (
  // Clock and reset
  input wire logic clk,
  input wire logic resetn,
  // Register port
  input wire logic regWrite,
  input wire logic regRead,
  input wire logic [lock_stamp_pkg::ADDR_W-1:0] regAddr,
  input wire logic [lock_stamp_pkg::DATA_W-1:0] regWdata,
  output logic [lock_stamp_pkg::DATA_W-1:0] regRdata,
  output logic regAck,
  // Sequence inputs, from pins
  input wire logic [1:0] activateInput,
  input wire logic [1:0] sleepInput,
  input wire logic slowUndervoltCross,
  input wire logic offThresholdCross,
  // Lock clear sources
  input wire logic softResetBit,
  input wire logic selfCheckDone,
  input wire logic shutdownSelftestOption,
  // Guarded write request from the wider register file
  input wire logic [2:0] guardGroup,
  input wire logic [2:0] guardChannel,
  input wire logic [lock_stamp_pkg::CHAN_N-1:0] channelLockSelect,
  output logic guardAllow,
  // State out
  output logic bankOne,
  output logic [lock_stamp_pkg::DATA_W-1:0] groupLockEffective
);
  import lock_stamp_pkg::*;

  ////////////////////////////////////////////////////////////////////////
  // Pin synchronisers, three flops, change accepted when last two agree
  logic [5:0] syncA_r;
  logic [5:0] syncB_r;
  logic [5:0] syncC_r;
  logic [5:0] pinStable_r;
  // Packed high to low: off, slow, sleep code, activate code
  wire [5:0] pinRaw = {offThresholdCross, slowUndervoltCross, sleepInput, activateInput};

  // First stage may go metastable; only the second stage reads it
  always_ff @(posedge clk) begin
    if (!resetn) begin
      syncA_r <= '0;
    end else begin
      syncA_r <= pinRaw;
    end
  end

  // Second and third stages; cleared so no unknown leaks past reset
  always_ff @(posedge clk) begin
    if (!resetn) begin
      syncB_r <= '0;
      syncC_r <= '0;
    end else begin
      syncB_r <= syncA_r;
      syncC_r <= syncB_r;
    end
  end

  // A bit moves only once stages two and three agree
  wire [5:0] pinAgree = ~(syncB_r ^ syncC_r);
  wire [5:0] pinStable_nxt = (pinAgree & syncC_r) | (~pinAgree & pinStable_r);
  always_ff @(posedge clk) begin
    if (!resetn) begin
      pinStable_r <= '0;
    end else begin
      pinStable_r <= pinStable_nxt;
    end
  end

  // Filtered pin views; a one-cycle glitch never reaches these
  wire [1:0] actCode = pinStable_r[1:0];
  wire [1:0] sleepCode = pinStable_r[3:2];
  wire riseCross = pinStable_r[4];
  wire fallCross = pinStable_r[5];

  ////////////////////////////////////////////////////////////////////////
  // Sequence state: a new 01 or 10 code on either input launches the timer
  typedef enum logic [1:0] {SEQ_IDLE, SEQ_RISE, SEQ_FALL} seq_t;
  seq_t seq_r, seq_nxt;
  logic [1:0] actPrev_r, sleepPrev_r;
  logic riseRaw, fallRaw;
  wire launchRise = ((actCode == CODE_RISE) && (actPrev_r != CODE_RISE))
    || ((sleepCode == CODE_RISE) && (sleepPrev_r != CODE_RISE));
  wire launchFall = ((actCode == CODE_FALL) && (actPrev_r != CODE_FALL))
    || ((sleepCode == CODE_FALL) && (sleepPrev_r != CODE_FALL));
  logic latched_r;
  always_comb begin
    seq_nxt = seq_r;
    riseRaw = 1'b0;
    fallRaw = 1'b0;
    case (seq_r)
      SEQ_IDLE: seq_nxt = SEQ_IDLE;
      SEQ_RISE: riseRaw = riseCross && !latched_r;
      SEQ_FALL: fallRaw = fallCross && !latched_r;
      default: seq_nxt = SEQ_IDLE;
    endcase
    if (launchRise) begin
      seq_nxt = SEQ_RISE;
    end else if (launchFall) begin
      seq_nxt = SEQ_FALL;
    end
  end
  wire captureNow = riseRaw || fallRaw;
  wire launchAny = launchRise || launchFall;

  // Sequence timer; tick divider sized from the 50 us figure
  logic [$clog2(TICK_CYCLES+1)-1:0] tickCnt_r;
  logic [STAMP_W-1:0] seqTimer_r;
  logic [STAMP_W-1:0] stamp_r;
  wire tickDone = (tickCnt_r == ($bits(tickCnt_r))'(TICK_CYCLES - 1));

  // Sequence state and last pin codes, kept for edge finding
  always_ff @(posedge clk) begin
    if (!resetn) begin
      seq_r <= SEQ_IDLE;
      actPrev_r <= '0;
      sleepPrev_r <= '0;
    end else begin
      seq_r <= seq_nxt;
      actPrev_r <= actCode;
      sleepPrev_r <= sleepCode;
    end
  end

  // Tick divider; a launch restarts it, so the first tick is a full period
  always_ff @(posedge clk) begin
    if (!resetn) begin
      tickCnt_r <= '0;
    end else if (launchAny || tickDone) begin
      tickCnt_r <= '0;
    end else begin
      tickCnt_r <= tickCnt_r + 1'h1;
    end
  end

  // Timer counts ticks; it stops at full scale rather than wrap
  always_ff @(posedge clk) begin
    if (!resetn) begin
      seqTimer_r <= '0;
    end else if (launchAny) begin
      seqTimer_r <= '0;
    end else if (tickDone && seqTimer_r != '1) begin
      seqTimer_r <= seqTimer_r + 1'h1;
    end
  end

  // One capture per sequence; a bouncing crossing is ignored
  always_ff @(posedge clk) begin
    if (!resetn) begin
      latched_r <= 1'h0;
    end else if (launchAny) begin
      latched_r <= 1'h0;
    end else if (captureNow) begin
      latched_r <= 1'h1;
    end
  end

  // Stamp keeps the timer value at the crossing until the next one
  always_ff @(posedge clk) begin
    if (!resetn) begin
      stamp_r <= '0;
    end else if (captureNow) begin
      stamp_r <= seqTimer_r;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Bank select and lock registers
  logic [DATA_W-1:0] bankSel_r;
  logic [DATA_W-1:0] lockA_r;
  logic [DATA_W-1:0] lockB_r;
  logic [DATA_W-1:0] bankSel_nxt;
  logic [DATA_W-1:0] lockA_nxt;
  logic [DATA_W-1:0] lockB_nxt;

  // Address match, shared by the write strobes and the read mux
  function automatic logic addrIs(input logic [ADDR_W-1:0] a, input logic [ADDR_W-1:0] ofs);
    return (a == ofs);
  endfunction : addrIs

  // Either clear source beats a host write in the same cycle
  wire lockClear = softResetBit || (selfCheckDone && shutdownSelftestOption);
  // Write strobes; a write to a stamp address decodes to nothing
  wire wrBank = regWrite && addrIs(regAddr, OFS_BANK_SEL);
  wire wrLockA = regWrite && addrIs(regAddr, OFS_LOCK_A);
  wire wrLockB = regWrite && addrIs(regAddr, OFS_LOCK_B);
  // Write-one-to-set: a zero written never drops a set bit
  assign lockA_nxt = lockClear ? RST_LOCK : (wrLockA ? (lockA_r | regWdata) : lockA_r);
  assign lockB_nxt = lockClear ? RST_LOCK : (wrLockB ? (lockB_r | regWdata) : lockB_r);
  assign bankSel_nxt = wrBank ? regWdata : bankSel_r;
  // Reserved bits are stored but masked off the effective lock
  wire [DATA_W-1:0] lockBoth = lockA_r & lockB_r & LOCK_USED_MASK;

  ////////////////////////////////////////////////////////////////////////
  // Group guard: decoder outside asks whether a write may land
  function automatic logic groupOpen(input logic [2:0] grp, input logic [2:0] ch,
                                     input logic [DATA_W-1:0] lk,
                                     input logic [CHAN_N-1:0] sel);
    logic open;
    open = 1'b1;
    case (grp)
      GRP_ORDERING: open = !lk[BIT_ORDERING];
      GRP_WATCH: open = !(lk[BIT_WATCH] && (ch < 3'(CHAN_N)) && sel[ch]);
      GRP_IRQEN: open = !lk[BIT_IRQEN];
      GRP_CONFIG: open = !lk[BIT_CONFIG];
      GRP_ORD_WORK: open = !lk[BIT_ORD_WORK];
      GRP_CTL_WORK: open = !lk[BIT_CTL_WORK];
      default: open = 1'b1;
    endcase
    return open;
  endfunction : groupOpen

  // Unmapped reads return zero
  wire [DATA_W-1:0] rdMux =
    addrIs(regAddr, OFS_STAMP_HIGH) ? stamp_r[STAMP_W-1:DATA_W] :
    addrIs(regAddr, OFS_STAMP_LOW) ? stamp_r[DATA_W-1:0] :
    addrIs(regAddr, OFS_BANK_SEL) ? bankSel_r :
    addrIs(regAddr, OFS_LOCK_A) ? lockA_r :
    addrIs(regAddr, OFS_LOCK_B) ? lockB_r : '0;

  // Bank select; all eight bits kept, so reads return what was written
  always_ff @(posedge clk) begin
    if (!resetn) begin
      bankSel_r <= RST_BANK_SEL;
    end else begin
      bankSel_r <= bankSel_nxt;
    end
  end

  // Lock halves; only reset or the clear sources ever drop a bit
  always_ff @(posedge clk) begin
    if (!resetn) begin
      lockA_r <= RST_LOCK;
      lockB_r <= RST_LOCK;
    end else begin
      lockA_r <= lockA_nxt;
      lockB_r <= lockB_nxt;
    end
  end

  // Read data held between reads, so a slow host may fetch it late
  always_ff @(posedge clk) begin
    if (!resetn) begin
      regRdata <= '0;
    end else if (regRead) begin
      regRdata <= rdMux;
    end
  end

  // Every access acks, locked or not; a lock never stalls the host
  always_ff @(posedge clk) begin
    if (!resetn) begin
      regAck <= 1'h0;
    end else begin
      regAck <= regRead || regWrite;
    end
  end

  // Guard answer one cycle after the request; open while in reset
  always_ff @(posedge clk) begin
    if (!resetn) begin
      guardAllow <= 1'h1;
    end else begin
      guardAllow <= groupOpen(guardGroup, guardChannel, lockBoth, channelLockSelect);
    end
  end

  // Status copies built from next values, so they track the registers
  always_ff @(posedge clk) begin
    if (!resetn) begin
      bankOne <= 1'h0;
      groupLockEffective <= '0;
    end else begin
      bankOne <= bankSel_nxt[BIT_BANK];
      groupLockEffective <= lockA_nxt & lockB_nxt & LOCK_USED_MASK;
    end
  end
endmodule : config_lock_and_timestamp_regs
`default_nettype wire

// *** design/lock_stamp_pkg.sv ***
// Purpose: Shared constants for the lock and timestamp register block
// Assumes: Byte-wide register port, 8-bit offsets
// Notes: Offsets are byte register addresses within the bank
package lock_stamp_pkg;
  localparam int ADDR_W = 8;
  localparam int DATA_W = 8;
  localparam int STAMP_W = 16;
  localparam int CHAN_N = 6;
  // Register offsets
  localparam logic [7:0] OFS_STAMP_HIGH = 8'h9A;
  localparam logic [7:0] OFS_STAMP_LOW = 8'h9B;
  localparam logic [7:0] OFS_BANK_SEL = 8'hF0;
  localparam logic [7:0] OFS_LOCK_A = 8'hF1;
  localparam logic [7:0] OFS_LOCK_B = 8'hF2;
  // Reset values
  localparam logic [7:0] RST_BANK_SEL = 8'h00;
  localparam logic [7:0] RST_LOCK = 8'h00;
  localparam logic [5:0] RST_CHAN_SEL = 6'h3F;
  localparam logic [7:0] LOCK_USED_MASK = 8'h3F;
  // Lock bit positions
  localparam int BIT_ORDERING = 0;
  localparam int BIT_WATCH = 1;
  localparam int BIT_IRQEN = 2;
  localparam int BIT_CONFIG = 3;
  localparam int BIT_ORD_WORK = 4;
  localparam int BIT_CTL_WORK = 5;
  localparam int BIT_BANK = 0;
  // Sequence control codes
  localparam logic [1:0] CODE_RISE = 2'b01;
  localparam logic [1:0] CODE_FALL = 2'b10;
  // Timestamp tick, 50 us, at 125 MHz
  localparam int TICK_NS = 50000;
  localparam int CLK_NS = 8;
  localparam int TICK_CYC = TICK_NS / CLK_NS;
  // Write group codes from the register decoder outside
  localparam logic [2:0] GRP_NONE = 3'd0;
  localparam logic [2:0] GRP_ORDERING = 3'd1;
  localparam logic [2:0] GRP_WATCH = 3'd2;
  localparam logic [2:0] GRP_IRQEN = 3'd3;
  localparam logic [2:0] GRP_CONFIG = 3'd4;
  localparam logic [2:0] GRP_ORD_WORK = 3'd5;
  localparam logic [2:0] GRP_CTL_WORK = 3'd6;
endpackage : lock_stamp_pkg

// *** dv/lock_regs_checker.sv ***
// Purpose: Port assertions for the lock and stamp registers
// Assumes: One clock, synchronous active-low reset
// Notes: Guard code n maps to lock bit n-1
`timescale 1ns/1ps
`default_nettype none
module lock_regs_checker
  import lock_stamp_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic resetn,
  // Register port
  input wire logic regWrite,
  input wire logic regRead,
  input wire logic [7:0] regAddr,
  input wire logic [7:0] regWdata,
  input wire logic [7:0] regRdata,
  input wire logic regAck,
  // Lock clear sources
  input wire logic softResetBit,
  input wire logic selfCheckDone,
  input wire logic shutdownSelftestOption,
  // Guard request and answer
  input wire logic [2:0] guardGroup,
  input wire logic [2:0] guardChannel,
  input wire logic [5:0] channelLockSelect,
  input wire logic guardAllow,
  // State out
  input wire logic bankOne,
  input wire logic [7:0] groupLockEffective
);
  default clocking @(posedge clk); endclocking
  default disable iff (!resetn);
  logic [2:0] clr_r;
  wire logic [2:0] lockIdx = guardGroup - 3'h1;
  wire logic hit = groupLockEffective[lockIdx] &&
    (guardGroup != GRP_WATCH || (guardChannel < 3'(CHAN_N) && channelLockSelect[guardChannel]));
  // Recent clears; the lock outputs may lag by a register or two
  always_ff @(posedge clk) begin
    clr_r <= {clr_r[1:0], softResetBit | (selfCheckDone & shutdownSelftestOption)};
  end
  chk_ack_follows: assert property ((regWrite || regRead) |=> regAck)
    else $error("ack missing");
  chk_ack_cause: assert property (regAck |-> $past(regWrite || regRead))
    else $error("stray ack");
  chk_rsvd_inert: assert property (groupLockEffective[7:6] == 2'h0)
    else $error("reserved lock bits active");
  chk_lock_sticky: assert property (|($past(groupLockEffective) & ~groupLockEffective) |-> |clr_r)
    else $error("lock cleared without cause");
  chk_soft_clear: assert property (softResetBit |-> ##[1:3] groupLockEffective == 8'h00)
    else $error("soft reset left locks");
  chk_guard_deny: assert property (hit |=> !guardAllow)
    else $error("locked write allowed");
  chk_guard_allow: assert property (!hit |=> guardAllow)
    else $error("free write denied");
  chk_bank_write: assert property (regWrite && regAddr == OFS_BANK_SEL |=> bankOne == $past(regWdata[0]))
    else $error("bank bit wrong");
  chk_bank_hold: assert property (!(regWrite && regAddr == OFS_BANK_SEL) |=> $stable(bankOne))
    else $error("bank bit moved");
  chk_rdata_hold: assert property (!regRead |=> $stable(regRdata))
    else $error("read data moved");
  cover property (hit);
  cover property (softResetBit && groupLockEffective != 8'h00);
  cover property (regRead && regAddr == OFS_STAMP_LOW);
endmodule : lock_regs_checker
bind config_lock_and_timestamp_regs lock_regs_checker chk (.*);
`default_nettype wire

// *** dv/rail_model.sv ***
// Purpose: Channel six rail and sequence pin model
// Assumes: Pins change at falling clock edges
// Notes: Rail starts fully off, below the off threshold
`timescale 1ns/1ps
`default_nettype none
module rail_model (
  // Clock
  input wire logic clk,
  // Sequence code pins
  output var logic [1:0] activateInput,
  output var logic [1:0] sleepInput,
  // Threshold crossing levels
  output var logic slowUndervoltCross,
  output var logic offThresholdCross
);
  initial {activateInput, sleepInput, slowUndervoltCross, offThresholdCross} = 6'h01;
  // Launch a code, cross its threshold d cycles later, let the stamp settle
  task automatic run(input logic [1:0] code, input bit viaSleep, input int d);
    @(negedge clk);
    if (viaSleep) sleepInput = code;
    else activateInput = code;
    {slowUndervoltCross, offThresholdCross} = 2'h0;
    repeat (d) @(negedge clk);
    if (code == 2'h1) slowUndervoltCross = 1'b1;
    else offThresholdCross = 1'b1;
    repeat (8) @(negedge clk);
  endtask : run
endmodule : rail_model
`default_nettype wire

// *** dv/tb.sv ***
// Purpose: Self-checking bench for the lock and stamp registers
// Assumes: Inputs change at falling edges, tick cut to 8 cycles
// Notes: Each access queues a note; reads carry expected data
`timescale 1ns/1ps
`default_nettype none
module tb;
  import lock_stamp_pkg::*;
  logic clk = 0, resetn = 0, regWrite = 0, regRead = 0, softResetBit = 0;
  logic selfCheckDone = 0, shutdownSelftestOption = 0, regAck, guardAllow, bankOne;
  logic [7:0] regAddr = 8'h00, regWdata = 8'h00, regRdata, groupLockEffective, v;
  logic [2:0] guardGroup = 3'h0, guardChannel = 3'h0;
  logic [5:0] channelLockSelect = 6'h3F;
  logic [1:0] activateInput, sleepInput;
  logic slowUndervoltCross, offThresholdCross;
  logic [8:0] expQ[$], e;
  int n_mismatch = 0, cmp_count = 0;
  initial forever #4 clk = ~clk;
  config_lock_and_timestamp_regs #(.TICK_CYCLES(8)) dut (.*);
  rail_model rail (.*);
  task automatic chk(input logic [7:0] got, exp);
    cmp_count++;
    if (got !== exp) begin
      n_mismatch++;
      $display("MISMATCH %0t got %h exp %h", $time, got, exp);
    end
  endtask : chk
  task automatic summarize();
    n_mismatch += expQ.size();
    $display("Compares %0d mismatches %0d", cmp_count, n_mismatch);
    if (n_mismatch == 0 && cmp_count > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask : summarize
  // One access per cycle; write notes skip the data compare
  task automatic op(input bit w, input logic [7:0] a, d);
    @(negedge clk);
    {regWrite, regRead, regAddr, regWdata} = {w, !w, a, d};
    expQ.push_back({!w, d});
  endtask : op
  // Bounded wait for all acks; a hang ends the run
  task automatic drain();
    @(negedge clk);
    {regWrite, regRead} = 2'h0;
    for (int i = 0; i < 9 && expQ.size() > 0; i++) @(negedge clk);
    if (expQ.size() > 0) summarize();
  endtask : drain
  task automatic clr(input bit s, o, input logic [7:0] x);
    {softResetBit, selfCheckDone, shutdownSelftestOption} = {s, !s, o};
    @(negedge clk);
    {softResetBit, selfCheckDone} = 2'h0;
    repeat (3) @(negedge clk);
    chk(groupLockEffective, x);
  endtask : clr
  // Oldest note pairs with each ack
  always @(negedge clk) begin
    if (regAck === 1'b1 && expQ.size() == 0) begin
      n_mismatch++;
      $display("MISMATCH %0t ack with no request", $time);
    end else if (regAck === 1'b1) begin
      e = expQ.pop_front();
      if (e[8]) chk(regRdata, e[7:0]);
    end
  end
  // Random guard traffic, judged by the checker
  always @(negedge clk) begin
    guardGroup <= 3'($urandom_range(6));
    guardChannel <= 3'($urandom_range(5));
    channelLockSelect <= 6'($urandom);
  end
  initial begin
    void'($urandom(6340));
    repeat (2) @(negedge clk);
    resetn = 1'b1;
    op(0, OFS_BANK_SEL, 8'h00);
    op(0, OFS_LOCK_A, 8'h00);
    op(0, OFS_LOCK_B, 8'h00);
    v = 8'($urandom);
    op(1, OFS_BANK_SEL, v);
    op(0, OFS_BANK_SEL, v);
    op(1, OFS_STAMP_LOW, 8'hFF);
    op(0, OFS_STAMP_LOW, 8'h00);
    op(0, 8'h55, 8'h00);
    op(1, OFS_LOCK_A, 8'h01);
    op(1, OFS_LOCK_A, 8'hC0);
    op(1, OFS_LOCK_B, 8'h3C);
    op(1, OFS_LOCK_A, 8'h00);
    op(0, OFS_LOCK_A, 8'hC1);
    drain();
    chk({7'h00, bankOne}, {7'h00, v[0]});
    chk(groupLockEffective, 8'h00);
    op(1, OFS_LOCK_A, 8'h3E);
    drain();
    chk(groupLockEffective, 8'h3C);
    clr(0, 0, 8'h3C);
    clr(0, 1, 8'h00);
    op(1, OFS_LOCK_A, 8'h11);
    op(1, OFS_LOCK_B, 8'h31);
    drain();
    clr(1, 0, 8'h00);
    op(0, OFS_LOCK_B, 8'h00);
    drain();
    rail.run(2'h1, 0, 8 * 260 + 4);
    op(0, OFS_STAMP_HIGH, 8'h01);
    op(0, OFS_STAMP_LOW, 8'h04);
    drain();
    rail.run(2'h2, 1, 8 * 3 + 4);
    op(0, OFS_STAMP_HIGH, 8'h00);
    op(0, OFS_STAMP_LOW, 8'h03);
    op(1, OFS_LOCK_A, 8'h01);
    drain();
    resetn = 1'b0;
    repeat (2) @(negedge clk);
    resetn = 1'b1;
    op(0, OFS_LOCK_A, 8'h00);
    drain();
    summarize();
  end
endmodule : tb
`default_nettype wire
